// ==== hdl/wdg_pulse.sv ====
// Stretches a one-cycle reset request into a fixed-width active-low reset pulse.
`timescale 1ns/1ps
module wdg_pulse #(
    parameter int WIDTH = 25
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic trig_i,
    output logic      rst_n_o
);
    logic [15:0] cnt_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 16'h0000;
        end else if (trig_i) begin
            cnt_reg <= 16'(WIDTH);
        end else if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rst_n_o <= 1'b1;
        end else begin
            rst_n_o <= !(trig_i || cnt_reg > 16'h0001);
        end
    end
endmodule : wdg_pulse

// ==== hdl/wdg_top.sv ====
// Seven-bit countdown watchdog with an AXI4-Lite register slave.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module wdg_top (
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        HW_OPTION_I,
    input  wire logic        HALT_I,
    input  wire logic        WAIT_I,
    input  wire logic        EXT_IRQ_I,
    input  wire logic [31:0] S_AXI_AWADDR_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    output logic [1:0]       S_AXI_BRESP_O,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    input  wire logic [31:0] S_AXI_ARADDR_I,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    output logic             WDG_RST_N_O
);
    localparam logic [15:0] PRESCALE_LAST = 16'(wdg_pkg::PRESCALE_CYCLES - 1);
    localparam logic [9:0]  WAKE_LAST     = 10'(wdg_pkg::WAKE_DELAY_CLKS - 1);

    logic                       activate_reg;
    logic [6:0]                 count_reg;
    logic [15:0]                prescale_reg;
    logic [9:0]                 wake_reg;
    wdg_pkg::wdg_mode_type      mode_reg;
    logic                       hw_opt_reg;
    logic                       wdg_reset_seen_reg;
    logic [31:0]                awaddr_reg;
    logic [31:0]                wdata_reg;
    logic [3:0]                 wstrb_reg;
    logic                       aw_held_reg;
    logic                       w_held_reg;
    logic                       fire;
    logic                       active;
    logic                       ctrl_write;
    logic                       counting;
    logic                       tick;
    logic [7:0]                 new_ctrl;

    // The option strap is sampled while reset is held so it is stable afterwards.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            hw_opt_reg <= HW_OPTION_I;
        end
    end

    assign active = hw_opt_reg || activate_reg;

    // Write channel capture: address and data may arrive in either order.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= 32'h0000_0000;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
        end else begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= S_AXI_AWADDR_I;
            end else if (ctrl_write || (aw_held_reg && w_held_reg)) begin
                aw_held_reg <= 1'b0;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= S_AXI_WDATA_I;
                wstrb_reg  <= S_AXI_WSTRB_I;
            end else if (aw_held_reg && w_held_reg) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O  <= 1'b0;
        end else begin
            S_AXI_AWREADY_O <= !aw_held_reg && !S_AXI_AWREADY_O && !S_AXI_BVALID_O
                               && S_AXI_AWVALID_I;
            S_AXI_WREADY_O  <= !w_held_reg && !S_AXI_WREADY_O && !S_AXI_BVALID_O
                               && S_AXI_WVALID_I;
        end
    end

    assign ctrl_write = aw_held_reg && w_held_reg && wstrb_reg[0]
                        && (awaddr_reg[7:2] == wdg_pkg::CTRL_ADDR[7:2])
                        && (awaddr_reg[31:8] == 24'h000000);
    assign new_ctrl = wdata_reg[7:0];

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O  <= wdg_pkg::RESP_OKAY;
        end else if (aw_held_reg && w_held_reg) begin
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O  <= (awaddr_reg[31:3] == 29'h0) ? wdg_pkg::RESP_OKAY
                                                          : wdg_pkg::RESP_SLVERR;
        end else if (S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
        end
    end

    // Read channel: one read at a time, answered one cycle after the address is taken.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O  <= 1'b0;
            S_AXI_RDATA_O   <= 32'h0000_0000;
            S_AXI_RRESP_O   <= wdg_pkg::RESP_OKAY;
        end else begin
            S_AXI_ARREADY_O <= S_AXI_ARVALID_I && !S_AXI_ARREADY_O && !S_AXI_RVALID_O;
            if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RRESP_O  <= wdg_pkg::RESP_OKAY;
                if (S_AXI_ARADDR_I == wdg_pkg::CTRL_ADDR) begin
                    S_AXI_RDATA_O <= {24'h000000, activate_reg, count_reg};
                end else if (S_AXI_ARADDR_I == wdg_pkg::STAT_ADDR) begin
                    S_AXI_RDATA_O <= {28'h0000000, wdg_reset_seen_reg, hw_opt_reg,
                                      mode_reg};
                end else begin
                    S_AXI_RDATA_O <= 32'h0000_0000;
                    S_AXI_RRESP_O <= wdg_pkg::RESP_SLVERR;
                end
            end else if (S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
    end

    // Wait mode does not stop the count: WAIT_I only keeps HALT_I from entering halt, so the count runs on.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            mode_reg <= wdg_pkg::RUN_STATE;
            wake_reg <= 10'h000;
        end else begin
            unique case (mode_reg)
                wdg_pkg::RUN_STATE: begin
                    if (HALT_I && !WAIT_I) begin
                        mode_reg <= wdg_pkg::HALT_STATE;
                    end
                end
                wdg_pkg::HALT_STATE: begin
                    if (EXT_IRQ_I) begin
                        mode_reg <= wdg_pkg::WAKE_STATE;
                        wake_reg <= 10'h000;
                    end
                end
                wdg_pkg::WAKE_STATE: begin
                    if (wake_reg == WAKE_LAST) begin
                        mode_reg <= wdg_pkg::RUN_STATE;
                    end else begin
                        wake_reg <= wake_reg + 10'h001;
                    end
                end
                default: begin
                    mode_reg <= wdg_pkg::RUN_STATE;
                end
            endcase
        end
    end

    assign counting = (mode_reg == wdg_pkg::RUN_STATE);
    assign tick     = counting && (prescale_reg == PRESCALE_LAST);

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            prescale_reg <= 16'h0000;
        end else if (ctrl_write) begin
            prescale_reg <= 16'h0000;
        end else if (counting) begin
            prescale_reg <= prescale_reg + 16'h0001;
        end
    end

    // A reset leaves the software watchdog disabled, including one that ends halt.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            activate_reg <= wdg_pkg::CTRL_RESET[wdg_pkg::ACT_BIT];
            count_reg    <= wdg_pkg::CTRL_RESET[6:0];
        end else begin
            if (ctrl_write && new_ctrl[wdg_pkg::ACT_BIT]) begin
                activate_reg <= 1'b1;
            end
            if (ctrl_write) begin
                count_reg <= new_ctrl[6:0];
            end else if (tick) begin
                count_reg <= count_reg - 7'h01;
            end
        end
    end

    // Expiry and software-forced reset; halt blocks expiry since count is held.
    always_comb begin
        fire = 1'b0;
        if (tick && active && count_reg == 7'h40) begin
            fire = 1'b1;
        end
        if (ctrl_write && !new_ctrl[wdg_pkg::TOP_BIT]
            && (new_ctrl[wdg_pkg::ACT_BIT] || active) && counting) begin
            fire = 1'b1;
        end
    end

    // Sticky marker that this block caused a reset; it survives nothing but power-up
    // in a real chip, here it is cleared by the next write to the control register so software can see it once.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            wdg_reset_seen_reg <= 1'b0;
        end else if (fire) begin
            wdg_reset_seen_reg <= 1'b1;
        end else if (ctrl_write) begin
            wdg_reset_seen_reg <= 1'b0;
        end
    end

    // The pulse is the only output toward the system; there is no interrupt.
    wdg_pulse #(
        .WIDTH (wdg_pkg::PULSE_CYCLES)
    ) u_pulse (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .trig_i  (fire),
        .rst_n_o (WDG_RST_N_O)
    );
endmodule : wdg_top

// ==== pkg/wdg_pkg.sv ====
// Package with register map, reset values and timing constants of the countdown watchdog.
package wdg_pkg;
    localparam logic [31:0] CTRL_ADDR        = 32'h0000_0000;
    localparam logic [31:0] STAT_ADDR        = 32'h0000_0004;
    localparam logic [7:0]  CTRL_RESET       = 8'h7f;
    localparam int          ACT_BIT          = 7;
    localparam int          TOP_BIT          = 6;
    localparam int          CLK_MHZ          = 50;
    localparam int          PRESCALE_CYCLES  = 65536;
    localparam int          WAKE_DELAY_CLKS  = 514;
    localparam int          PULSE_NS         = 500;
    localparam int          CLK_PERIOD_NS    = 1000 / CLK_MHZ;
    // Typical width, so rounded down but never below one cycle.
    localparam int          PULSE_CYCLES     = (PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                               (PULSE_NS / CLK_PERIOD_NS);
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    typedef enum logic [1:0] {
        RUN_STATE   = 2'h0,
        HALT_STATE  = 2'h1,
        WAKE_STATE  = 2'h2
    } wdg_mode_type;
endpackage : wdg_pkg

// ==== test/wdg_assertions.sv ====
// Concurrent checks on the countdown watchdog ports.
`timescale 1ns/1ps
module wdg_assertions (
    input wire logic        CLK_I,
    input wire logic        RST_N_I,
    input wire logic        HALT_I,
    input wire logic        WAIT_I,
    input wire logic        EXT_IRQ_I,
    input wire logic        S_AXI_AWVALID_I,
    input wire logic        S_AXI_AWREADY_O,
    input wire logic        S_AXI_BVALID_O,
    input wire logic        S_AXI_BREADY_I,
    input wire logic        S_AXI_ARVALID_I,
    input wire logic        S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic [1:0]  S_AXI_RRESP_O,
    input wire logic        S_AXI_RVALID_O,
    input wire logic        S_AXI_RREADY_I,
    input wire logic        WDG_RST_N_O
);
    logic [7:0] low_cnt_reg;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    // Counts sampled low cycles so the full pulse width is checked at its end.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I || WDG_RST_N_O) low_cnt_reg <= 8'h00;
        else low_cnt_reg <= low_cnt_reg + 8'h01;
    end
    pulse_width_a: assert property ($rose(WDG_RST_N_O) |-> low_cnt_reg == wdg_pkg::PULSE_CYCLES)
        else $error("reset pulse width wrong");
    halt_blocks_reset_a: assert property ((HALT_I && !WAIT_I && !EXT_IRQ_I) [*8]
        |=> !$fell(WDG_RST_N_O)) else $error("reset pulse during halt");
    reset_idle_a: assert property ($rose(RST_N_I) |-> WDG_RST_N_O && !S_AXI_BVALID_O)
        else $error("outputs not idle after reset");
    write_answer_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O
        |-> ##[1:3] S_AXI_BVALID_O) else $error("write response missing");
    bresp_drop_a: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
        else $error("write response not released");
    read_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
        else $error("read data late");
    rresp_drop_a: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O)
        else $error("read data not released");
    slverr_zero_a: assert property (S_AXI_RVALID_O && S_AXI_RRESP_O == wdg_pkg::RESP_SLVERR
        |-> S_AXI_RDATA_O == 32'h0) else $error("error read not zero");
    cover property ($fell(WDG_RST_N_O));
    cover property (S_AXI_RVALID_O && S_AXI_RRESP_O == wdg_pkg::RESP_SLVERR);
    cover property (HALT_I && EXT_IRQ_I);
endmodule : wdg_assertions
bind wdg_top wdg_assertions u_wdg_assertions (.CLK_I, .RST_N_I, .HALT_I, .WAIT_I, .EXT_IRQ_I,
    .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARVALID_I,
    .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RRESP_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I,
    .WDG_RST_N_O);

// ==== test/wdg_top_test.sv ====
// Self-checking testbench of the countdown watchdog.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
    $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module wdg_top_test;
    logic CLK_I = 1'b0, RST_N_I = 1'b0, HW_OPTION_I = 1'b0, HALT_I = 1'b0, WAIT_I = 1'b0;
    logic EXT_IRQ_I = 1'b0, S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0;
    logic S_AXI_BREADY_I = 1'b0, S_AXI_ARVALID_I = 1'b0, S_AXI_RREADY_I = 1'b0;
    logic [31:0] S_AXI_AWADDR_I = 32'h0, S_AXI_WDATA_I = 32'h0, S_AXI_ARADDR_I = 32'h0;
    logic [3:0]  S_AXI_WSTRB_I = 4'h0;
    logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
    logic [1:0]  S_AXI_BRESP_O, S_AXI_RRESP_O, r;
    logic [31:0] S_AXI_RDATA_O, d;
    logic        WDG_RST_N_O;
    logic [7:0]  cur, v;
    int          err_count = 0, n_checks = 0, cyc = 0;
    wdg_top u_wdg_top (.CLK_I, .RST_N_I, .HW_OPTION_I, .HALT_I, .WAIT_I, .EXT_IRQ_I,
        .S_AXI_AWADDR_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WDATA_I, .S_AXI_WSTRB_I,
        .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I,
        .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RRESP_O,
        .S_AXI_RVALID_O, .S_AXI_RREADY_I, .WDG_RST_N_O);
    always #10 CLK_I = ~CLK_I;
    task automatic summarize();
        if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    always @(posedge CLK_I) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end
    // A written zero never clears the activate bit; the count bits load at once.
    function automatic logic [7:0] exp_ctrl(input logic [7:0] old, input logic [7:0] wr);
        return {old[7] | wr[7], wr[6:0]};
    endfunction : exp_ctrl
    task automatic rst();
        @(posedge CLK_I) RST_N_I <= 1'b0;
        repeat (16) @(posedge CLK_I);
        RST_N_I <= 1'b1;
    endtask : rst
    task automatic wr(input logic [31:0] a, input logic [31:0] dat, output logic [1:0] rs);
        bit aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge CLK_I);
        S_AXI_AWADDR_I <= a;
        S_AXI_WDATA_I <= dat;
        S_AXI_WSTRB_I <= 4'hf;
        S_AXI_AWVALID_I <= 1'b1;
        S_AXI_WVALID_I <= 1'b1;
        S_AXI_BREADY_I <= 1'b1;
        while (!(aw && w)) begin
            @(posedge CLK_I);
            if (S_AXI_AWREADY_O === 1'b1) begin aw = 1'b1; S_AXI_AWVALID_I <= 1'b0; end
            if (S_AXI_WREADY_O === 1'b1) begin w = 1'b1; S_AXI_WVALID_I <= 1'b0; end
        end
        do @(posedge CLK_I); while (S_AXI_BVALID_O !== 1'b1);
        rs = S_AXI_BRESP_O;
        S_AXI_BREADY_I <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] dat, output logic [1:0] rs);
        @(posedge CLK_I);
        S_AXI_ARADDR_I <= a;
        S_AXI_ARVALID_I <= 1'b1;
        S_AXI_RREADY_I <= 1'b1;
        do @(posedge CLK_I); while (S_AXI_ARREADY_O !== 1'b1);
        S_AXI_ARVALID_I <= 1'b0;
        do @(posedge CLK_I); while (S_AXI_RVALID_O !== 1'b1);
        dat = S_AXI_RDATA_O;
        rs = S_AXI_RRESP_O;
        S_AXI_RREADY_I <= 1'b0;
    endtask : rd
    // The pulse starts one edge before the write answer is seen, so the level
    // standing on entry is counted too; sixty cycles cover the whole low pulse.
    task automatic pulse(input bit expect_fire);
        int lo;
        lo = (WDG_RST_N_O === 1'b0) ? 1 : 0;
        repeat (59) begin
            @(posedge CLK_I);
            if (WDG_RST_N_O === 1'b0) lo++;
        end
        `CHK(lo, expect_fire ? wdg_pkg::PULSE_CYCLES : 0)
    endtask : pulse
    initial begin
        void'($urandom(32'h76b9));
        rst();
        rd(wdg_pkg::CTRL_ADDR, d, r); `CHK(d[7:0], wdg_pkg::CTRL_RESET)
        rd(wdg_pkg::STAT_ADDR, d, r); `CHK(d[2:0], 3'h0)
        wr(wdg_pkg::CTRL_ADDR, 32'h3f, r); pulse(1'b0);
        rd(wdg_pkg::CTRL_ADDR, d, r); `CHK(d[7], 1'b0)
        cur = 8'h3f;
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'hc0 : (i == 1) ? 8'hff : 8'hc0 | 8'($urandom_range(63, 0));
            wr(wdg_pkg::CTRL_ADDR, {24'h0, v}, r);
            cur = exp_ctrl(cur, v);
            rd(wdg_pkg::CTRL_ADDR, d, r); `CHK(d[7:0], cur)
        end
        wr(wdg_pkg::CTRL_ADDR, 32'h45, r);
        cur = exp_ctrl(cur, 8'h45);
        rd(wdg_pkg::CTRL_ADDR, d, r); `CHK(d[7:0], cur)
        HALT_I <= 1'b1;
        repeat (10) @(posedge CLK_I);
        rd(wdg_pkg::STAT_ADDR, d, r); `CHK(d[1:0], wdg_pkg::HALT_STATE)
        wr(wdg_pkg::CTRL_ADDR, 32'h80, r); pulse(1'b0);
        EXT_IRQ_I <= 1'b1;
        @(posedge CLK_I);
        EXT_IRQ_I <= 1'b0;
        HALT_I <= 1'b0;
        repeat (490) @(posedge CLK_I);
        rd(wdg_pkg::STAT_ADDR, d, r); `CHK(d[1:0], wdg_pkg::WAKE_STATE)
        repeat (30) @(posedge CLK_I);
        rd(wdg_pkg::STAT_ADDR, d, r); `CHK(d[1:0], wdg_pkg::RUN_STATE)
        WAIT_I <= 1'b1;
        HALT_I <= 1'b1;
        wr(wdg_pkg::CTRL_ADDR, 32'h80, r); pulse(1'b1);
        rd(wdg_pkg::STAT_ADDR, d, r); `CHK(d[3], 1'b1)
        WAIT_I <= 1'b0;
        HALT_I <= 1'b0;
        rst();
        rd(wdg_pkg::CTRL_ADDR, d, r); `CHK(d[7:0], wdg_pkg::CTRL_RESET)
        rd(wdg_pkg::STAT_ADDR, d, r); `CHK(d[3:0], 4'h0)
        HW_OPTION_I <= 1'b1;
        rst();
        rd(wdg_pkg::STAT_ADDR, d, r); `CHK(d[2], 1'b1)
        wr(wdg_pkg::CTRL_ADDR, 32'h3f, r); pulse(1'b1);
        HW_OPTION_I <= 1'b0;
        rst();
        rd(32'h10, d, r); `CHK(r, wdg_pkg::RESP_SLVERR)
        `CHK(d, 32'h0)
        wr(wdg_pkg::STAT_ADDR, 32'hff, r); `CHK(r, wdg_pkg::RESP_OKAY)
        wr(32'h20, 32'h80, r); `CHK(r, wdg_pkg::RESP_SLVERR)
        rd(wdg_pkg::CTRL_ADDR, d, r); `CHK(d[7:0], wdg_pkg::CTRL_RESET)
        summarize();
    end
endmodule : wdg_top_test
